/* core/pwm_channel.sv */
// Purpose: One 8-bit PWM channel timer with double-buffered period and duty.
// Assumes: tick is a one-cycle enable pulse at the selected channel clock rate.
// Notes: Output flip-flop is kept as the waveform level itself.
`timescale 1ns/100ps
module pwm_channel (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Control
    input wire logic tick,
    input wire pwm_pkg::chan_cfg_t cfg,
    input wire pwm_pkg::chan_evt_t evt,
    // State
    output pwm_pkg::chan_stat_t stat
);
    import pwm_pkg::*;

    logic [CW-1:0] cnt_r, per_r, dty_r;
    logic down_r, wave_r, armed_r;
    logic [CW-1:0] cnt_nxt, per_nxt, dty_nxt;
    logic down_nxt, wave_nxt;

    // Counting waits for the first tick after enabling, so a waveform starts on a clock edge.
    wire run = cfg.enable && armed_r && tick;
    wire left_end = !cfg.center && (per_r == 8'h00 || cnt_r + 8'h01 >= per_r);
    wire ctr_top = cfg.center && !down_r && (cnt_r + 8'h01 >= per_r);
    wire ctr_end = cfg.center && down_r && (cnt_r <= 8'h01);
    wire idle_zero = !cfg.enable && tick && per_r == 8'h00 && cnt_r != 8'h00;

    always_comb begin
        cnt_nxt = cnt_r;
        per_nxt = per_r;
        dty_nxt = dty_r;
        down_nxt = down_r;
        wave_nxt = wave_r;
        if (!cfg.enable) begin
            // Disabled: latches follow writes at once; counter holds, but clears on a tick once the period latch is zero.
            per_nxt = cfg.period_buf;
            dty_nxt = cfg.duty_buf;
        end
        if (evt.cnt_wr) begin
            cnt_nxt = 8'h00;
            down_nxt = 1'b0;
            per_nxt = cfg.period_buf;
            dty_nxt = cfg.duty_buf;
            wave_nxt = cfg.polarity;
        end else if (idle_zero) begin
            cnt_nxt = 8'h00;
        end else if (run) begin
            if (left_end) begin
                cnt_nxt = 8'h00;
                wave_nxt = cfg.polarity;
                per_nxt = cfg.period_buf;
                dty_nxt = cfg.duty_buf;
            end else if (ctr_end) begin
                cnt_nxt = 8'h00;
                down_nxt = 1'b0;
                per_nxt = cfg.period_buf;
                dty_nxt = cfg.duty_buf;
                wave_nxt = (cnt_r - 8'h01 == dty_r) ? !wave_r : wave_r;
            end else begin
                cnt_nxt = (cfg.center && down_r) ? cnt_r - 8'h01 : cnt_r + 8'h01;
                if (ctr_top) begin
                    down_nxt = 1'b1;
                end
                // Toggle when the count about to show equals duty.
                if (cnt_nxt == dty_r) begin
                    wave_nxt = !wave_r;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cnt_r <= 8'h00;
            per_r <= 8'h00;
            dty_r <= 8'h00;
            down_r <= 1'b0;
            wave_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            per_r <= per_nxt;
            dty_r <= dty_nxt;
            down_r <= down_nxt;
            wave_r <= wave_nxt;
            armed_r <= cfg.enable && (armed_r || tick);
        end
    end

    assign stat.count = cnt_r;
    assign stat.wave = wave_r;

endmodule : pwm_channel

/* core/pwm_core.sv */
// Purpose: Six-channel 8-bit PWM with prescaled and scaled clocks, AXI4-Lite registers.
// Assumes: Single 125 MHz clock; slower clocks are one-cycle enable pulses.
// Notes: Outputs are registered; channel waveforms leave through PWM_OUT.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module pwm_core (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // System
    input wire logic FREEZE,
    // AXI4-Lite write address
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Waveforms
    output logic [pwm_pkg::NCH-1:0] PWM_OUT
);
    import pwm_pkg::*;

    // ****************************************
    // Register file
    // ****************************************
    logic [NCH-1:0] channel_enable_bit_r, channel_polarity_bit_r, channel_clock_sel_r, center_align_bit_r;
    logic [7:0] prescale_select_word_r, control_word_r, first_scale_value_r, second_scale_value_r;
    logic [CW-1:0] per_buf_r [NCH];
    logic [CW-1:0] dty_buf_r [NCH];

    // ****************************************
    // Bus slave
    // ****************************************
    logic [7:0] awaddr_r, araddr_r;
    logic aw_have_r, w_have_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    wire do_write = aw_have_r && w_have_r && !S_AXI_BVALID;
    wire [7:0] wbyte = wstrb_r[0] ? wdata_r[7:0] : 8'h00;
    wire wlane = wstrb_r[0];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Channel register decode; returns index + valid.
    function automatic logic [3:0] chan_of(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        chan_of = (a >= base && d[1:0] == 2'b00 && d[7:2] < 6'(NCH)) ? {1'b1, d[4:2]} : 4'h0;
    endfunction : chan_of

    wire [3:0] w_cnt = chan_of(awaddr_r, OFF_CNT0);
    wire [3:0] w_per = chan_of(awaddr_r, OFF_PER0);
    wire [3:0] w_dty = chan_of(awaddr_r, OFF_DTY0);
    wire [3:0] r_cnt = chan_of(S_AXI_ARADDR, OFF_CNT0);
    wire [3:0] r_per = chan_of(S_AXI_ARADDR, OFF_PER0);
    wire [3:0] r_dty = chan_of(S_AXI_ARADDR, OFF_DTY0);

    wire w_known = hit(awaddr_r, OFF_ENABLE) || hit(awaddr_r, OFF_POLARITY) || hit(awaddr_r, OFF_CLKSEL)
                   || hit(awaddr_r, OFF_PRESCALE) || hit(awaddr_r, OFF_ALIGN) || hit(awaddr_r, OFF_CONTROL)
                   || hit(awaddr_r, OFF_SCALE_A) || hit(awaddr_r, OFF_SCALE_B) || w_cnt[3] || w_per[3] || w_dty[3];

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_r <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= w_known ? RESP_OKAY : RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    // Only byte lane 0 carries data; other lanes are read-as-zero.
    wire wr_en = do_write && wlane;
    wire wr_scale_a = wr_en && hit(awaddr_r, OFF_SCALE_A);
    wire wr_scale_b = wr_en && hit(awaddr_r, OFF_SCALE_B);

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            channel_enable_bit_r <= '0;
            channel_polarity_bit_r <= '0;
            channel_clock_sel_r <= '0;
            center_align_bit_r <= '0;
            prescale_select_word_r <= RST_BYTE;
            control_word_r <= RST_BYTE;
            first_scale_value_r <= RST_BYTE;
            second_scale_value_r <= RST_BYTE;
        end else if (wr_en) begin
            if (hit(awaddr_r, OFF_ENABLE)) channel_enable_bit_r <= wbyte[NCH-1:0];
            if (hit(awaddr_r, OFF_POLARITY)) channel_polarity_bit_r <= wbyte[NCH-1:0];
            if (hit(awaddr_r, OFF_CLKSEL)) channel_clock_sel_r <= wbyte[NCH-1:0];
            if (hit(awaddr_r, OFF_ALIGN)) center_align_bit_r <= wbyte[NCH-1:0];
            if (hit(awaddr_r, OFF_PRESCALE)) prescale_select_word_r <= {1'b0, wbyte[6:4], 1'b0, wbyte[2:0]};
            if (hit(awaddr_r, OFF_CONTROL)) control_word_r <= {6'h00, wbyte[1:0]};
            if (wr_scale_a) first_scale_value_r <= wbyte;
            if (wr_scale_b) second_scale_value_r <= wbyte;
        end
    end

    // ****************************************
    // Clock generation
    // ****************************************
    // Prescaler input is gated so all derived clocks freeze together.
    wire freeze_gate_bit = control_word_r[POS_FREEZE_GATE];
    wire idle_gate = control_word_r[POS_IDLE_GATE] && (channel_enable_bit_r == '0);
    wire pre_run = !(freeze_gate_bit && FREEZE) && !idle_gate;

    logic [6:0] pre_cnt_r;
    always_ff @(posedge CLK) begin
        if (!NRST) pre_cnt_r <= 7'h00;
        else if (pre_run) pre_cnt_r <= pre_cnt_r + 7'h01;
    end

    // Rate 2^sel: tick when the low sel bits of the free counter are all ones.
    function automatic logic pre_tick(input logic [6:0] c, input logic [2:0] sel);
        logic [6:0] m;
        m = 7'((8'h01 << sel) - 8'h01);
        pre_tick = ((c & m) == m);
    endfunction : pre_tick

    wire first_prescale_sel_tick = pre_run && pre_tick(pre_cnt_r, prescale_select_word_r[POS_PRE_A +: 3]);
    wire second_prescale_sel_tick = pre_run && pre_tick(pre_cnt_r, prescale_select_word_r[POS_PRE_B +: 3]);

    logic [7:0] down_a_r, down_b_r;
    logic half_a_r, half_b_r;
    wire pulse_a = first_prescale_sel_tick && (down_a_r == 8'h01);
    wire pulse_b = second_prescale_sel_tick && (down_b_r == 8'h01);
    wire scaled_a_tick = pulse_a && half_a_r;
    wire scaled_b_tick = pulse_b && half_b_r;

    // Loading zero counts 256 steps through wrap to 0xff, giving the /512 rate.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            down_a_r <= 8'h00;
            down_b_r <= 8'h00;
            half_a_r <= 1'b0;
            half_b_r <= 1'b0;
        end else begin
            if (wr_scale_a) down_a_r <= wbyte;
            else if (pulse_a) down_a_r <= first_scale_value_r;
            else if (first_prescale_sel_tick) down_a_r <= down_a_r - 8'h01;
            if (wr_scale_b) down_b_r <= wbyte;
            else if (pulse_b) down_b_r <= second_scale_value_r;
            else if (second_prescale_sel_tick) down_b_r <= down_b_r - 8'h01;
            if (pulse_a) half_a_r <= !half_a_r;
            if (pulse_b) half_b_r <= !half_b_r;
        end
    end

    // ****************************************
    // Channels
    // ****************************************
    chan_stat_t stat [NCH];

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gen_ch
            wire grp_b = (g == 2) || (g == 3);
            wire t_pre = grp_b ? second_prescale_sel_tick : first_prescale_sel_tick;
            wire t_scl = grp_b ? scaled_b_tick : scaled_a_tick;
            wire ch_tick = channel_clock_sel_r[g] ? t_scl : t_pre;
            chan_cfg_t cfg;
            chan_evt_t evt;
            assign cfg.enable = channel_enable_bit_r[g];
            assign cfg.polarity = channel_polarity_bit_r[g];
            assign cfg.center = center_align_bit_r[g];
            assign cfg.period_buf = per_buf_r[g];
            assign cfg.duty_buf = dty_buf_r[g];
            assign evt.cnt_wr = wr_en && w_cnt[3] && (w_cnt[2:0] == 3'(g));
            assign evt.per_wr = wr_en && w_per[3] && (w_per[2:0] == 3'(g));
            assign evt.dty_wr = wr_en && w_dty[3] && (w_dty[2:0] == 3'(g));

            always_ff @(posedge CLK) begin
                if (!NRST) begin
                    per_buf_r[g] <= 8'h00;
                    dty_buf_r[g] <= 8'h00;
                end else begin
                    if (evt.per_wr) per_buf_r[g] <= wbyte;
                    if (evt.dty_wr) dty_buf_r[g] <= wbyte;
                end
            end

            pwm_channel u_ch (
                .CLK(CLK),
                .NRST(NRST),
                .tick(ch_tick),
                .cfg(cfg),
                .evt(evt),
                .stat(stat[g])
            );

            // Disabled channels hold low at the pin.
            always_ff @(posedge CLK) begin
                if (!NRST) PWM_OUT[g] <= 1'b0;
                else PWM_OUT[g] <= channel_enable_bit_r[g] && stat[g].wave;
            end
        end
    endgenerate

    // ****************************************
    // Read path
    // ****************************************
    logic [7:0] rbyte;
    logic r_known;
    always_comb begin
        rbyte = 8'h00;
        r_known = 1'b1;
        if (hit(S_AXI_ARADDR, OFF_ENABLE)) rbyte = 8'(channel_enable_bit_r);
        else if (hit(S_AXI_ARADDR, OFF_POLARITY)) rbyte = 8'(channel_polarity_bit_r);
        else if (hit(S_AXI_ARADDR, OFF_CLKSEL)) rbyte = 8'(channel_clock_sel_r);
        else if (hit(S_AXI_ARADDR, OFF_ALIGN)) rbyte = 8'(center_align_bit_r);
        else if (hit(S_AXI_ARADDR, OFF_PRESCALE)) rbyte = prescale_select_word_r;
        else if (hit(S_AXI_ARADDR, OFF_CONTROL)) rbyte = control_word_r;
        else if (hit(S_AXI_ARADDR, OFF_SCALE_A)) rbyte = first_scale_value_r;
        else if (hit(S_AXI_ARADDR, OFF_SCALE_B)) rbyte = second_scale_value_r;
        else if (r_cnt[3]) rbyte = stat[r_cnt[2:0]].count;
        else if (r_per[3]) rbyte = per_buf_r[r_per[2:0]];
        else if (r_dty[3]) rbyte = dty_buf_r[r_dty[2:0]];
        else r_known = 1'b0;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {24'h000000, rbyte};
            S_AXI_RRESP <= r_known ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

endmodule : pwm_core

/* pkg/pwm_pkg.sv */
// Purpose: Shared constants and carrier types for the six-channel PWM core.
// Assumes: 32-bit AXI4-Lite register bus, one word per register.
// Notes: Register offsets are byte addresses.
package pwm_pkg;

    localparam int NCH = 6;
    localparam int CW = 8;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFF_ENABLE = 8'h00;
    localparam logic [7:0] OFF_POLARITY = 8'h04;
    localparam logic [7:0] OFF_CLKSEL = 8'h08;
    localparam logic [7:0] OFF_PRESCALE = 8'h0c;
    localparam logic [7:0] OFF_ALIGN = 8'h10;
    localparam logic [7:0] OFF_CONTROL = 8'h14;
    localparam logic [7:0] OFF_SCALE_A = 8'h18;
    localparam logic [7:0] OFF_SCALE_B = 8'h1c;
    localparam logic [7:0] OFF_CNT0 = 8'h20;
    localparam logic [7:0] OFF_PER0 = 8'h40;
    localparam logic [7:0] OFF_DTY0 = 8'h60;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int POS_PRE_A = 0;
    localparam int POS_PRE_B = 4;
    localparam int POS_FREEZE_GATE = 0;
    localparam int POS_IDLE_GATE = 1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Per-channel configuration carried into each channel timer.
    typedef struct packed {
        logic enable;
        logic polarity;
        logic center;
        logic [CW-1:0] period_buf;
        logic [CW-1:0] duty_buf;
    } chan_cfg_t;

    // One-cycle software events for a channel.
    typedef struct packed {
        logic cnt_wr;
        logic per_wr;
        logic dty_wr;
    } chan_evt_t;

    // Observable channel state.
    typedef struct packed {
        logic [CW-1:0] count;
        logic wave;
    } chan_stat_t;

endpackage : pwm_pkg

/* verif/pwm_clock_and_channel_timers_test.sv */
// Purpose: Self-checking bench for the six-channel PWM core.
// Assumes: 125 MHz clock, registers reached over AXI4-Lite.
// Notes: Waveforms are judged by high time over one whole effective period.
`timescale 1ns/100ps
module pwm_clock_and_channel_timers_test;
    import pwm_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic freeze = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [NCH-1:0] pwm;
    logic [34:0] rq[$];
    logic [1:0] bq[$];
    logic [34:0] e;
    int err_count = 0, total_checks = 0, cyc = 0, seed = 32'h6b2c;
    logic [7:0] offs[10] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h40, 8'h60, 8'h54, 8'h74};
    logic [7:0] msk[10] = '{8'h3f, 8'h3f, 8'h77, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    pwm_core i_dut (.CLK(clk), .NRST(nrst), .FREEZE(freeze), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PWM_OUT(pwm));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic summarize();
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // ****************************************
    // Response watcher and hang limit
    // ****************************************
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            summarize();
        end
        if (rvalid && rready) begin
            e = rq.pop_front();
            chk({rresp, e[34] ? rdata : e[31:0]}, e[33:0]);
        end
        if (bvalid && bready) chk(34'(bresp), 34'(bq.pop_front()));
    end

    // rready is raised a cycle late on purpose so that the slave must hold its read answer; bready rises in the same cycle as bvalid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        bq.push_back(r);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        rq.push_back({r == RESP_OKAY, r, 24'h000000, d});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask : rd

    task automatic wave(input int ch, ctr, pol, sc, input logic [7:0] pre, scl, per, dty, input int hi, win);
        logic [7:0] b;
        int n;
        b = 8'h01 << ch;
        n = 0;
        wr(OFF_ENABLE, 8'h00);
        wr(OFF_POLARITY, pol ? b : 8'h00);
        wr(OFF_CLKSEL, sc ? b : 8'h00);
        wr(OFF_ALIGN, ctr ? b : 8'h00);
        wr(OFF_PRESCALE, pre);
        wr(OFF_SCALE_A, scl);
        wr(OFF_SCALE_B, scl);
        wr(OFF_PER0 + 8'(4 * ch), per);
        wr(OFF_DTY0 + 8'(4 * ch), dty);
        wr(OFF_CNT0 + 8'(4 * ch), 8'h00);
        wr(OFF_ENABLE, b);
        repeat (2 * win + 20) @(posedge clk);
        repeat (win) begin
            @(posedge clk);
            if (pwm[ch] === 1'b1) n++;
        end
        chk(34'(n), 34'(hi));
        chk(34'(pwm & ~b[NCH-1:0]), 34'h0);
    endtask : wave

    initial begin
        logic [7:0] v, p, d;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 128; a += 4) rd(8'(a), 8'h00, (a inside {56, 60, 88, 92, 120, 124}) ? RESP_SLVERR : RESP_OKAY);
        wr(8'h38, 8'h5a, RESP_SLVERR);
        // A write without byte lane 0 is answered but leaves the register alone.
        wstrb <= 4'h0;
        wr(OFF_SCALE_B, 8'h5a);
        wstrb <= 4'hf;
        rd(OFF_SCALE_B, 8'h00);
        foreach (offs[i]) begin
            v = 8'($random(seed)) & msk[i];
            wr(offs[i], v);
            rd(offs[i], v);
        end
        wave(0, 0, 1, 0, 8'h00, 8'h00, 8'd4, 8'd1, 1, 4);
        wave(1, 0, 0, 0, 8'h00, 8'h00, 8'd4, 8'd1, 3, 4);
        wave(4, 1, 0, 0, 8'h00, 8'h00, 8'd4, 8'd1, 6, 8);
        wave(5, 1, 1, 0, 8'h00, 8'h00, 8'd5, 8'd2, 4, 10);
        wave(0, 0, 1, 1, 8'h00, 8'h02, 8'd4, 8'd1, 4, 16);
        wave(2, 0, 1, 0, 8'h10, 8'h00, 8'd4, 8'd1, 2, 8);
        wave(3, 0, 1, 1, 8'h00, 8'h00, 8'd2, 8'd1, 512, 1024);
        p = 8'd2 + (8'($random(seed)) & 8'h1f);
        d = 8'd1 + 8'($unsigned($random(seed)) % (p - 1));
        wave(1, 0, 1, 0, 8'h03, 8'h00, p, d, 8 * d, 8 * p);
        wr(OFF_ENABLE, 8'h00);
        wr(OFF_PRESCALE, 8'h00);
        wr(OFF_CONTROL, 8'h01);
        freeze <= 1'b1;
        wr(OFF_PER0, 8'd200);
        wr(OFF_CNT0, 8'h00);
        wr(OFF_ENABLE, 8'h01);
        repeat (40) @(posedge clk);
        rd(OFF_CNT0, 8'h00);
        freeze <= 1'b0;
        repeat (40) @(posedge clk);
        wr(OFF_ENABLE, 8'h00);
        wr(OFF_CNT0, 8'h77);
        rd(OFF_CNT0, 8'h00);
        // Ticks come every clock here, so the counts follow the bus timing exactly.
        wr(OFF_ENABLE, 8'h01);
        wr(OFF_CNT0, 8'h00);
        rd(OFF_CNT0, 8'h01);
        wr(OFF_ENABLE, 8'h00);
        rd(OFF_CNT0, 8'h06);
        repeat (8) @(posedge clk);
        rd(OFF_CNT0, 8'h06);
        wr(OFF_ENABLE, 8'h01);
        repeat (30) @(posedge clk);
        wr(OFF_ENABLE, 8'h00);
        wr(OFF_PER0, 8'h00);
        repeat (4) @(posedge clk);
        rd(OFF_CNT0, 8'h00);
        summarize();
    end
endmodule : pwm_clock_and_channel_timers_test

/* verif/pwm_core_chk.sv */
// Purpose: Port-level assertions for the PWM core.
// Assumes: Writes to the enable word carry byte lane 0.
// Notes: Enable state is tracked from completed register writes.
`timescale 1ns/100ps
module pwm_core_chk
    import pwm_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Write channels
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // Read channels
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Waveforms
    input wire logic [NCH-1:0] PWM_OUT
);
    logic [7:0] aw_r;
    logic [NCH-1:0] wd_r;
    logic [NCH-1:0] en_r;

    // The enable copy follows the response, so the output check allows a few cycles of slack.
    always_ff @(posedge CLK) begin
        if (S_AXI_AWVALID && S_AXI_AWREADY) aw_r <= S_AXI_AWADDR;
        if (S_AXI_WVALID && S_AXI_WREADY) wd_r <= S_AXI_WDATA[NCH-1:0];
        if (!NRST) en_r <= '0;
        else if (S_AXI_BVALID && aw_r == OFF_ENABLE) en_r <= wd_r;
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    AST_RESET_IDLE: assert property (disable iff (1'b0) !NRST |=> PWM_OUT == '0 && !S_AXI_BVALID && !S_AXI_RVALID)
        else $error("outputs not idle after reset");
    AST_DISABLED_LOW: assert property ((PWM_OUT & ~(en_r | $past(en_r) | $past(en_r, 2) | $past(en_r, 3))) == '0)
        else $error("disabled channel drives its output");
    AST_WRITE_ANSWER: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##[1:2] S_AXI_BVALID) else $error("write response missing");
    AST_WRITE_BLOCK: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
    AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped early");
    AST_READ_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data late");
    AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped early");
    AST_RDATA_UPPER: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_UNMAPPED: assert property (S_AXI_BVALID && aw_r == 8'h38 |-> S_AXI_BRESP == RESP_SLVERR)
        else $error("unmapped write not refused");

    COV_SLVERR: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
    COV_CH0: cover property ($rose(PWM_OUT[0]));
    COV_CH3: cover property ($fell(PWM_OUT[3]));
endmodule : pwm_core_chk

bind pwm_core pwm_core_chk i_chk (.CLK, .NRST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .PWM_OUT);
